// ==== hw/fsp_pkg.sv ====
// Package with constants for the frequency synthesis and fine phase block
// ----------------------------------------------------------------------
// How it works
// - Output frequency is reference times multiply/divide
// - Second output is the exact inverse
// - Both outputs have equal high and low
// - Standalone synthesis ignores the feedback clock
// - Edges realign every divide-factor reference cycles
// - Fine delay shifts all outputs together
// - Fixed granularity: period/256 or one step
// - Mode selects disabled, fixed or variable shift
// - Fixed delay equals value/256 of period
// - Zero aligns; positive later, negative earlier
// - Enable with direction on adjust clock edge
// - Done output synchronous to adjust clock; here done_r is registered on pclk
// - Variable operations clocked by adjust clock; here they are clocked by pclk on synchronised adjust edges
// - Adjust inputs have selectable polarity
// - Each enabled edge adds or subtracts one step; here only while idle, and the count holds at +/-MAX_STEPS
// - Settle 100 ref plus 3 adjust, done pulse
// - Manager reset returns variable shift to zero
// ----------------------------------------------------------------------
package fsp_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] FSP_CTRL_ADDR = 8'h00;
  localparam logic [7:0] FSP_RATIO_ADDR = 8'h04;
  localparam logic [7:0] FSP_PHASE_ADDR = 8'h08;
  localparam logic [7:0] FSP_STATUS_ADDR = 8'h0C;

  // Control fields
  localparam int FSP_CTRL_MODE_LSB = 0;
  localparam int FSP_CTRL_DLL_BIT = 2;
  localparam int FSP_CTRL_RST_BIT = 3;
  localparam int FSP_CTRL_INV_EN_BIT = 4;
  localparam int FSP_CTRL_INV_CLK_BIT = 5;
  localparam int FSP_CTRL_INV_DIR_BIT = 6;
  // Ratio fields
  localparam int FSP_RATIO_MULT_LSB = 0;
  localparam int FSP_RATIO_DIV_LSB = 8;
  // Status fields
  localparam int FSP_STAT_STEP_LSB = 16;
  localparam int FSP_STAT_BUSY_BIT = 25;
  localparam int FSP_STAT_CFGERR_BIT = 26;
  localparam int FSP_STAT_REF_BIT = 27;
  localparam int FSP_STAT_FB_BIT = 28;

  // Reset values
  localparam logic [5:0] FSP_MULT_RST = 6'h02;
  localparam logic [5:0] FSP_DIV_RST = 6'h01;
  localparam logic [8:0] FSP_PHASE_RST = 9'h000;

  // Legal factor ranges
  localparam logic [5:0] FSP_MULT_MIN = 6'h02;
  localparam logic [5:0] FSP_MULT_MAX = 6'h20;
  localparam logic [5:0] FSP_DIV_MIN = 6'h01;
  localparam logic [5:0] FSP_DIV_MAX = 6'h20;

  // Phase shift modes
  typedef enum logic [1:0] {
    FSP_MODE_NONE = 2'h0,
    FSP_MODE_FIXED = 2'h1,
    FSP_MODE_VARIABLE = 2'h2
  } fsp_mode_t;

  // Variable shift sequencer, Gray along the path
  typedef enum logic [1:0] {
    FSP_PS_IDLE = 2'b00,
    FSP_PS_SETTLE = 2'b01,
    FSP_PS_TAIL = 2'b11,
    FSP_PS_DONE = 2'b10
  } fsp_ps_state_t;

  // Timing counts
  localparam logic [6:0] FSP_SETTLE_REF_CYC = 7'd100;
  localparam logic [1:0] FSP_SETTLE_ADJ_CYC = 2'd3;
  localparam int FSP_FRAC_SHIFT = 8;

endpackage

// ==== hw/fsp_freq_synth_phase_shift.sv ====
// Frequency synthesizer with fine phase shift, APB register slave
//
// The implementer's own choices: register access over APB and the register offsets.
module fsp_freq_synth_phase_shift #(
  parameter int REF_CNT_W = 16,
  parameter int MAX_STEPS = 255,
  parameter int STEP_PCLK = 1
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic ref_clk_in,
  input wire logic feedback_clk_in,
  output logic synth_clk_out,
  output logic synth_clk_out_inv,
  // Phase adjust port
  input wire logic phase_adjust_clock,
  input wire logic phase_adjust_enable,
  input wire logic phase_adjust_direction,
  output logic phase_adjust_done
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (REF_CNT_W < 8 || REF_CNT_W > 24) begin : g_bad_w
    $error("REF_CNT_W must be 8 to 24");
  end
  if (MAX_STEPS < 1 || MAX_STEPS > 255) begin : g_bad_s
    $error("MAX_STEPS must be 1 to 255");
  end
  if (STEP_PCLK < 1 || STEP_PCLK > 255) begin : g_bad_p
    $error("STEP_PCLK must be 1 to 255");
  end

  localparam int ACC_W = REF_CNT_W + 7;
  localparam logic signed [8:0] STEP_MAX = 9'(MAX_STEPS);
  localparam logic [8:0] STEP_CYC = 9'(STEP_PCLK);

  // Registers
  logic [1:0] mode_r;
  logic use_dll_r, mgr_rst_r;
  logic [2:0] inv_r;
  logic [5:0] mult_r, div_r;
  logic [8:0] phase_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------------
  // Pin synchronisers: ref, fb, adj clk, adj en, adj dir
  // ----------------------------------------------------------------------
  logic [4:0] pin_raw, sync1_r, sync2_r, sync3_r;
  assign pin_raw = {phase_adjust_direction, phase_adjust_enable, phase_adjust_clock,
                    feedback_clk_in, ref_clk_in};

  // First stage feeds the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic ref_rise, fb_rise, adj_rise, adj_en, adj_dir;
  assign ref_rise = sync2_r[0] & ~sync3_r[0];
  assign fb_rise = sync2_r[1] & ~sync3_r[1];
  // Polarity per input chosen by software
  assign adj_rise = (sync2_r[2] ^ inv_r[1]) & ~(sync3_r[2] ^ inv_r[1]);
  assign adj_en = sync2_r[3] ^ inv_r[0];
  assign adj_dir = sync2_r[4] ^ inv_r[2];

  // Configuration sanity: illegal factors stop the outputs
  logic cfg_err;
  assign cfg_err = (mult_r < FSP_MULT_MIN) || (mult_r > FSP_MULT_MAX) ||
                   (div_r < FSP_DIV_MIN) || (div_r > FSP_DIV_MAX);

  // ----------------------------------------------------------------------
  // Reference period measurement
  // ----------------------------------------------------------------------
  logic [REF_CNT_W-1:0] ref_cnt_r, ref_per_r;
  logic ref_seen_r;
  logic [5:0] frame_cnt_r;
  logic frame_wrap;
  assign frame_wrap = ref_rise && (frame_cnt_r + 6'h01 >= div_r);

  // Period counter saturates so a stopped reference reads as long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= '0;
      ref_per_r <= '0;
      ref_seen_r <= 1'b0;
    end else if (ref_rise) begin
      ref_cnt_r <= REF_CNT_W'(1);
      ref_per_r <= ref_cnt_r;
      ref_seen_r <= 1'b1;
    end else if (ref_cnt_r != '1) begin
      ref_cnt_r <= ref_cnt_r + REF_CNT_W'(1);
    end
  end

  // Counts reference cycles into frames of divide-factor length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_r <= 6'h00;
    end else if (frame_wrap) begin
      frame_cnt_r <= 6'h00;
    end else if (ref_rise) begin
      frame_cnt_r <= frame_cnt_r + 6'h01;
    end
  end

  // Feedback activity seen during the last frame
  logic fb_hit_r, fb_active_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_hit_r <= 1'b0;
      fb_active_r <= 1'b0;
    end else if (frame_wrap) begin
      fb_hit_r <= fb_rise;
      fb_active_r <= fb_hit_r | fb_rise;
    end else if (fb_rise) begin
      fb_hit_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Variable shift sequencer
  // ----------------------------------------------------------------------
  fsp_ps_state_t ps_state_r;
  logic signed [8:0] step_r;
  logic [6:0] settle_r;
  logic [1:0] tail_r;
  logic done_r;

  // Request taken only on an enabled adjust edge while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_state_r <= FSP_PS_IDLE;
      step_r <= 9'sh000;
      settle_r <= 7'h00;
      tail_r <= 2'h0;
      done_r <= 1'b0;
    end else if (mgr_rst_r || mode_r != FSP_MODE_VARIABLE) begin
      ps_state_r <= FSP_PS_IDLE;
      step_r <= 9'sh000;
      settle_r <= 7'h00;
      tail_r <= 2'h0;
      done_r <= 1'b0;
    end else begin
      case (ps_state_r)
        FSP_PS_IDLE: begin
          if (adj_rise) begin
            done_r <= 1'b0;
          end
          if (adj_rise && adj_en) begin
            if (adj_dir && step_r < STEP_MAX) begin
              step_r <= step_r + 9'sh001;
            end else if (!adj_dir && step_r > -STEP_MAX) begin
              step_r <= step_r - 9'sh001;
            end
            settle_r <= 7'h00;
            ps_state_r <= FSP_PS_SETTLE;
          end
        end
        FSP_PS_SETTLE: begin
          // Worst-case wait in reference cycles
          if (ref_rise) begin
            settle_r <= settle_r + 7'h01;
            if (settle_r + 7'h01 >= FSP_SETTLE_REF_CYC) begin
              tail_r <= 2'h0;
              ps_state_r <= FSP_PS_TAIL;
            end
          end
        end
        FSP_PS_TAIL: begin
          if (adj_rise) begin
            tail_r <= tail_r + 2'h1;
            if (tail_r + 2'h1 >= FSP_SETTLE_ADJ_CYC) begin
              done_r <= 1'b1;
              ps_state_r <= FSP_PS_DONE;
            end
          end
        end
        FSP_PS_DONE: begin
          // Done stands for one adjust clock period
          if (adj_rise) begin
            done_r <= 1'b0;
            ps_state_r <= FSP_PS_IDLE;
          end
        end
        default: begin
          ps_state_r <= FSP_PS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fine delay in pclk cycles, folded into one reference period in fixed mode; variable mode only adds one period to a negative amount
  // ----------------------------------------------------------------------
  logic signed [REF_CNT_W+9:0] fix_prod;
  logic signed [REF_CNT_W+9:0] var_prod;
  logic signed [REF_CNT_W+9:0] raw_dly;
  logic [REF_CNT_W-1:0] fine_dly;
  assign fix_prod = $signed(phase_r) * $signed({1'b0, ref_per_r});
  // Operands widen to the target before the product, so no step count is cut
  assign var_prod = $signed(step_r) * $signed({1'b0, STEP_CYC});

  // Negative shift becomes a delay of period minus the amount
  always_comb begin
    raw_dly = '0;
    case (mode_r)
      FSP_MODE_FIXED: raw_dly = fix_prod >>> FSP_FRAC_SHIFT;
      FSP_MODE_VARIABLE: raw_dly = var_prod;
      default: raw_dly = '0;
    endcase
    if (raw_dly < 0) begin
      raw_dly = raw_dly + $signed({10'h000, ref_per_r});
    end
    fine_dly = raw_dly[REF_CNT_W-1:0];
  end

  // ----------------------------------------------------------------------
  // Synthesizer: half-period accumulator with frame realignment
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0] acc_r, acc_sum, half_lim;
  logic [REF_CNT_W-1:0] align_cnt_r;
  logic align_pend_r, synth_r;
  assign acc_sum = acc_r + ACC_W'({mult_r, 1'b0});
  assign half_lim = ACC_W'(ref_per_r) * ACC_W'(div_r);

  // Toggle each time 2*mult*pclk ticks cover period*div: f = fref*M/D
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
      synth_r <= 1'b0;
      align_cnt_r <= '0;
      align_pend_r <= 1'b0;
    end else if (mgr_rst_r || cfg_err || !ref_seen_r) begin
      acc_r <= '0;
      synth_r <= 1'b0;
      align_pend_r <= 1'b0;
    end else begin
      // Standalone mode never looks at feedback or realigns
      if (frame_wrap && use_dll_r) begin
        align_cnt_r <= fine_dly;
        align_pend_r <= 1'b1;
      end else if (align_pend_r && align_cnt_r != '0) begin
        align_cnt_r <= align_cnt_r - REF_CNT_W'(1);
      end
      if (align_pend_r && align_cnt_r == '0 && !(frame_wrap && use_dll_r)) begin
        acc_r <= '0;
        synth_r <= 1'b1;
        align_pend_r <= 1'b0;
      end else if (acc_sum >= half_lim) begin
        acc_r <= acc_sum - half_lim;
        synth_r <= ~synth_r;
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  assign synth_clk_out = synth_r;
  assign synth_clk_out_inv = ~synth_r;
  assign phase_adjust_done = done_r;

  // ----------------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------------
  logic wr_acc, rd_setup, addr_ok;
  assign addr_ok = (paddr == FSP_CTRL_ADDR) || (paddr == FSP_RATIO_ADDR) ||
                   (paddr == FSP_PHASE_ADDR) || (paddr == FSP_STATUS_ADDR);
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  // Writable configuration; status is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= FSP_MODE_NONE;
      use_dll_r <= 1'b0;
      mgr_rst_r <= 1'b0;
      inv_r <= 3'h0;
      mult_r <= FSP_MULT_RST;
      div_r <= FSP_DIV_RST;
      phase_r <= FSP_PHASE_RST;
    end else if (wr_acc) begin
      case (paddr)
        FSP_CTRL_ADDR: begin
          mode_r <= pwdata[FSP_CTRL_MODE_LSB +: 2];
          use_dll_r <= pwdata[FSP_CTRL_DLL_BIT];
          mgr_rst_r <= pwdata[FSP_CTRL_RST_BIT];
          inv_r <= {pwdata[FSP_CTRL_INV_DIR_BIT], pwdata[FSP_CTRL_INV_CLK_BIT],
                    pwdata[FSP_CTRL_INV_EN_BIT]};
        end
        FSP_RATIO_ADDR: begin
          mult_r <= pwdata[FSP_RATIO_MULT_LSB +: 6];
          div_r <= pwdata[FSP_RATIO_DIV_LSB +: 6];
        end
        FSP_PHASE_ADDR: begin
          phase_r <= pwdata[8:0];
        end
        default: begin
          phase_r <= phase_r;
        end
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        FSP_CTRL_ADDR: prdata_r <= {25'h0, inv_r[2], inv_r[1], inv_r[0],
                                    mgr_rst_r, use_dll_r, mode_r};
        FSP_RATIO_ADDR: prdata_r <= {18'h0, div_r, 2'h0, mult_r};
        FSP_PHASE_ADDR: prdata_r <= {23'h0, phase_r};
        FSP_STATUS_ADDR: prdata_r <= {3'h0, fb_active_r, ref_seen_r, cfg_err,
                                      ps_state_r != FSP_PS_IDLE, step_r,
                                      16'(ref_per_r)};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== verif/fsp_monitor.sv ====
// Port checker for the synthesizer and phase adjust block
module fsp_monitor
  import fsp_pkg::*;
(
  // Register bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Clocks and adjust port
  input wire logic ref_clk_in,
  input wire logic synth_clk_out,
  input wire logic synth_clk_out_inv,
  input wire logic phase_adjust_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_r, ratio_r;
  logic [2:0] ref_s_r;
  logic [7:0] nref_r;
  wire logic wr = psel && penable && pwrite;
  wire logic bad_a = paddr[1:0] != 2'h0 || paddr > FSP_STATUS_ADDR;
  wire logic bad_cfg = ratio_r[5:0] < FSP_MULT_MIN || ratio_r[5:0] > FSP_MULT_MAX ||
    ratio_r[13:8] < FSP_DIV_MIN || ratio_r[13:8] > FSP_DIV_MAX;
  // Copy of control and ratio writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h00000000;
      ratio_r <= 32'h00000102;
    end else if (wr && paddr == FSP_CTRL_ADDR) begin
      ctrl_r <= pwdata;
    end else if (wr && paddr == FSP_RATIO_ADDR) begin
      ratio_r <= pwdata;
    end
  end
  // Reference edges since the last done, saturating so it cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s_r <= 3'h0;
      nref_r <= 8'h00;
    end else begin
      ref_s_r <= {ref_s_r[1:0], ref_clk_in};
      if (phase_adjust_done) begin
        nref_r <= 8'h00;
      end else if (ref_s_r[1] && !ref_s_r[2] && nref_r < 8'hC8) begin
        nref_r <= nref_r + 8'h01;
      end
    end
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_done_hold;
    phase_adjust_done [*6];
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_ready_now: assert property (s_access |-> pready)
    else $error("access phase not answered at once");
  chk_err_map: assert property (s_access |-> pslverr == bad_a)
    else $error("error flag does not match address map");
  chk_bad_read: assert property (s_access ##0 (!pwrite && bad_a) |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  chk_read_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved outside a read");
  chk_inv_exact: assert property (synth_clk_out_inv == !synth_clk_out)
    else $error("second output is not the inverse");
  chk_cfg_idle: assert property (bad_cfg [*3] |-> !synth_clk_out)
    else $error("output runs with illegal factors");
  chk_mgr_rst: assert property (ctrl_r[3] [*3] |-> !synth_clk_out)
    else $error("output runs in manager reset");
  chk_done_len: assert property ($rose(phase_adjust_done) |=> s_done_hold ##[1:4] !phase_adjust_done)
    else $error("done pulse length wrong");
  chk_done_settle: assert property ($rose(phase_adjust_done) |-> nref_r >= 8'h64)
    else $error("done before settling time");
  chk_done_mode: assert property ($rose(phase_adjust_done) |-> ctrl_r[1:0] == FSP_MODE_VARIABLE)
    else $error("done outside variable mode");
endmodule

bind fsp_freq_synth_phase_shift fsp_monitor i_fsp_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
  .synth_clk_out(synth_clk_out), .synth_clk_out_inv(synth_clk_out_inv),
  .phase_adjust_done(phase_adjust_done));

// ==== verif/fsp_fabric_model.sv ====
// Fabric logic model driving the phase adjust port
module fsp_fabric_model (
  // Commands from the bench
  input wire logic go,
  input wire logic up,
  input wire logic tie_low,
  input wire logic [2:0] pol,
  // Phase adjust port
  input wire logic phase_adjust_done,
  output logic phase_adjust_clock,
  output logic phase_adjust_enable,
  output logic phase_adjust_direction,
  output int n_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_r = 1'b0;
  logic en_r = 1'b0;
  logic dir_r = 1'b0;
  logic wait_r = 1'b0;
  wire logic pin_clk = clk_r ^ pol[1];
  initial n_done = 0;
  // Own adjust clock, unrelated to the bus clock
  always #170 clk_r = ~clk_r;
  // Change on the falling pin edge so requests are steady at the rising one
  always @(negedge pin_clk) begin
    if (phase_adjust_done) begin
      n_done <= n_done + 1;
      wait_r <= 1'b0;
    end
    if (en_r) begin
      en_r <= 1'b0;
    end else if (go && !wait_r && !tie_low) begin
      en_r <= 1'b1;
      dir_r <= up;
      wait_r <= 1'b1;
    end
  end
  // Polarity at the pins; all held low when unused
  assign phase_adjust_clock = !tie_low && pin_clk;
  assign phase_adjust_enable = !tie_low && (en_r ^ pol[0]);
  assign phase_adjust_direction = !tie_low && (dir_r ^ pol[2]);
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the synthesizer block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, ref_clk = 1'b0, synth, synth_inv, aclk, aen, adir, done;
  logic go = 1'b0, up = 1'b0, tie = 1'b0, meas = 1'b0;
  logic [2:0] pol = 3'h0;
  int n_fail = 0, n_checks = 0, n_done, cyc = 0, n_rise, hi, lo;
  logic [13:0] rat[4] = '{14'h0305, 14'h0102, 14'h0205, 14'h2020};
  logic [13:0] bad[4] = '{14'h0101, 14'h0121, 14'h0002, 14'h2102};
  logic [9:0] stp[4] = '{10'h201, 10'h000, 10'h1FF, 10'h1FE};
  int ph[6] = '{0, 12, 13, 64, -64, 255};
  fsp_freq_synth_phase_shift i_fsp_freq_synth_phase_shift (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk),
    .feedback_clk_in(synth), .synth_clk_out(synth), .synth_clk_out_inv(synth_inv),
    .phase_adjust_clock(aclk), .phase_adjust_enable(aen),
    .phase_adjust_direction(adir), .phase_adjust_done(done));
  fsp_fabric_model i_fsp_fabric_model (.go(go), .up(up), .tie_low(tie), .pol(pol),
    .phase_adjust_done(done), .phase_adjust_clock(aclk), .phase_adjust_enable(aen),
    .phase_adjust_direction(adir), .n_done(n_done));
  // Bus clock; reference has 30% high time to show duty correction
  initial forever #20 pclk = ~pclk;
  initial begin
    #7;
    forever begin
      ref_clk = 1'b1;
      #240;
      ref_clk = 1'b0;
      #560;
    end
  end
  // Rise and level counts of the output while a window is open
  always @(posedge synth) if (meas) n_rise++;
  // Levels sampled mid-cycle, away from the edge that moves the output
  always @(negedge pclk) begin
    if (meas && synth) hi++;
    if (meas && !synth) lo++;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    q = prdata;
    e = pslverr;
    if (t == 20) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic near(input string nm, input int x, input int g, input int tol);
    n_checks++;
    if (g > x + tol || g < x - tol) begin
      n_fail++;
      $display("FAIL %s expected %0d seen %0d", nm, x, g);
    end
  endtask
  task automatic window(input int n);
    n_rise = 0;
    hi = 0;
    lo = 0;
    meas = 1'b1;
    repeat (n) @(posedge ref_clk);
    meas = 1'b0;
  endtask
  // Offset of the first output rise after a reference rise, in bus cycles
  task automatic shift(output int d);
    time t0;
    repeat (4) @(posedge ref_clk);
    t0 = $time;
    @(posedge synth);
    d = int'(($time - t0 + 20) / 40);
  endtask
  // One adjust request; waits for the k-th done, bounded
  task automatic adj(input logic dir, input int k);
    int t = 0;
    up <= dir;
    go <= 1'b1;
    while (n_done < k && t < 4000) begin
      @(posedge pclk);
      t++;
    end
    go <= 1'b0;
    if (t == 4000) n_fail++;
  endtask
  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    int d0, d;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(FSP_RATIO_ADDR, q);
    cmp("ratio", 32'h00000102, q);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, q, e);
    apb(1'b0, 8'h10, 32'h00000000, q, e);
    cmp("unmapped", 32'h00000000, q);
    cmp("slverr", 32'h00000001, {31'h0, e});
    wr(FSP_STATUS_ADDR, 32'hFFFFFFFF);
    rd(FSP_STATUS_ADDR, q);
    cmp("status", 32'h00000000, q & 32'h07FF0000);
    // Standalone ratios, boundary factors included
    foreach (rat[i]) begin
      wr(FSP_RATIO_ADDR, {18'h0, rat[i]});
      repeat (3) @(posedge ref_clk);
      window(30);
      near("edges", 30 * rat[i][5:0] / rat[i][13:8], n_rise, 1);
      near("duty", hi, lo, 2);
    end
    // Illegal factors keep the output idle
    foreach (bad[i]) begin
      wr(FSP_RATIO_ADDR, {18'h0, bad[i]});
      repeat (2) @(posedge ref_clk);
      window(4);
      rd(FSP_STATUS_ADDR, q);
      cmp("cfgerr", 32'h00000001, {31'h0, q[FSP_STAT_CFGERR_BIT]});
      near("idle", 0, n_rise, 0);
    end
    // Fixed shift, realigned each frame
    tie <= 1'b1;
    wr(FSP_RATIO_ADDR, 32'h00000202);
    wr(FSP_CTRL_ADDR, 32'h00000005);
    foreach (ph[i]) begin
      wr(FSP_PHASE_ADDR, ph[i] & 32'h1FF);
      rd(FSP_PHASE_ADDR, q);
      cmp("phase", ph[i] & 32'h1FF, q);
      shift(d);
      if (i == 0) d0 = d;
      near("fixed", (ph[i] * 20 / 256 + 20) % 20, (d - d0 + 40) % 20, 0);
    end
    wr(FSP_CTRL_ADDR, 32'h00000004);
    shift(d);
    near("none", 0, (d - d0 + 40) % 20, 0);
    // Variable steps, last one with all pins inverted
    tie <= 1'b0;
    wr(FSP_PHASE_ADDR, 32'h00000000);
    wr(FSP_CTRL_ADDR, 32'h00000006);
    foreach (stp[i]) begin
      if (i == 3) begin
        // Flip polarity just after an adjust edge, so no pin edge is in the synchronisers
        @(posedge aclk);
        wr(FSP_CTRL_ADDR, 32'h00000076);
        pol <= 3'h7;
      end
      adj(stp[i][9], i + 1);
      rd(FSP_STATUS_ADDR, q);
      cmp("step", {23'h0, stp[i][8:0]}, {23'h0, q[24:16]});
      if (i == 0 || i == 2) begin
        shift(d);
        near("vshift", i == 0 ? 1 : 19, (d - d0 + 40) % 20, 0);
      end
    end
    wr(FSP_CTRL_ADDR, 32'h0000007E);
    rd(FSP_STATUS_ADDR, q);
    cmp("rststep", 32'h00000000, {23'h0, q[24:16]});
    close_out();
  end
endmodule
